// [logic/fsr_params.svh]
`ifndef FSR_PARAMS_SVH
`define FSR_PARAMS_SVH

// Status byte one bit positions
`define FSR_S1_EOC      7
`define FSR_S1_CRC      5
`define FSR_S1_LATE     4
`define FSR_S1_NOSEC    2
`define FSR_S1_WPROT    1
`define FSR_S1_NOMARK   0
// Status byte two bit positions
`define FSR_S2_MMATCH   6
`define FSR_S2_DCRC     5
`define FSR_S2_TRK      4
`define FSR_S2_BAD      1
`define FSR_S2_NODAM    0
// Status byte three bit positions
`define FSR_S3_WP       6
`define FSR_S3_ONE_HI   5
`define FSR_S3_T0       4
`define FSR_S3_ONE_LO   3
`define FSR_S3_HD       2
`define FSR_S3_DS_HI    1
`define FSR_S3_DS_LO    0

`define FSR_BYTE_ZERO   8'h00
`define FSR_HARD_TRACK  8'hFF
`define FSR_LAST_SECTOR 8'hFF
`define FSR_IDX_LIMIT   2'h2

`endif

// [logic/fsr_pkg.sv]
package fsr_pkg;

    typedef enum logic [2:0] {
        FSR_CMD_OTHER,
        FSR_CMD_READ_DATA,
        FSR_CMD_READ_DELETED,
        FSR_CMD_WRITE_DATA,
        FSR_CMD_WRITE_DELETED,
        FSR_CMD_FORMAT,
        FSR_CMD_READ_ID,
        FSR_CMD_READ_TRACK
    } fsr_cmd_t;

    typedef enum logic [1:0] {
        FSR_ST_RESET,
        FSR_ST_IDLE,
        FSR_ST_EXEC
    } fsr_state_t;

    // Events reported by the disk engine, one-cycle pulses
    typedef struct packed {
        logic       sector_past_end;
        logic       data_cmd_end;
        logic       terminal_count;
        logic       id_crc_fail;
        logic       data_crc_fail;
        logic       service_late;
        logic       sector_missing;
        logic       id_read_fail;
        logic       sequence_wrong;
        logic       index_pulse_pin;
        logic       id_mark_seen;
        logic       no_data_mark;
        logic       deleted_mark;
        logic       normal_mark;
        logic       id_valid;
        logic [7:0] id_track;
    } fsr_event_t;

    // Live drive pins
    typedef struct packed {
        logic       write_protect_pin;
        logic       track_zero_pin;
        logic       head_select_pin;
        logic [1:0] drive_select_state;
    } fsr_pins_t;

endpackage : fsr_pkg

// [logic/fsr_status_reset.sv]
`include "fsr_params.svh"

module fsr_status_reset (
    input  wire logic               clk,              // Core clock
    input  wire logic               rst,              // Hardware reset pin, active high
    input  wire logic               ce,               // Clock enable
    input  wire logic               cmd_start,        // New command accepted
    input  wire fsr_pkg::fsr_cmd_t  cmd_kind,         // Command being started
    input  wire logic [7:0]         cur_track,        // Internally held track
    input  wire fsr_pkg::fsr_event_t evt,             // Disk engine events
    input  wire fsr_pkg::fsr_pins_t  pins,            // Drive pins
    input  wire logic               ocr_reset_wr,     // Write to output-control reset bit
    input  wire logic               ocr_reset_val,    // Value written
    input  wire logic               rate_reset_wr,    // Rate-select reset bit set
    input  wire logic               power_down_req,   // Enter power down
    input  wire logic               cfg_wr,           // Configure command
    input  wire logic               cfg_poll_dis,     // Configure polling disable
    input  wire logic [7:0]         cfg_val,          // Configure settings
    input  wire logic               spec_wr,          // Specify command
    input  wire logic [7:0]         spec_val,         // Specify settings
    output logic [7:0]              result_status_one, // Result byte one
    output logic [7:0]              result_status_two, // Result byte two
    output logic [7:0]              drive_state_status, // Drive state byte
    output logic                    core_reset,       // Core held in reset
    output logic                    ocr_reset_bit,    // Readback of reset bit
    output logic                    power_down,       // Power down state
    output logic                    poll_enable,      // Drive polling running
    output logic [7:0]              cfg_settings,     // Stored configure value
    output logic [7:0]              spec_settings,    // Stored specify value
    output fsr_pkg::fsr_state_t     core_state        // Idle, executing or reset
);

    logic [7:0]          st1_q, st1_d;
    logic [7:0]          st2_q, st2_d;
    logic [7:0]          st3_q, st3_d;
    logic                ocr_q, rate_q, pd_q, poll_q, srst_q;
    logic [7:0]          cfg_q, spec_q;
    logic [1:0]          idx_q;
    fsr_pkg::fsr_cmd_t   cmd_q;
    fsr_pkg::fsr_state_t state_q, state_d;

    function automatic logic is_write(input fsr_pkg::fsr_cmd_t c);
        is_write = (c == fsr_pkg::FSR_CMD_WRITE_DATA) ||
                   (c == fsr_pkg::FSR_CMD_WRITE_DELETED) ||
                   (c == fsr_pkg::FSR_CMD_FORMAT);
    endfunction : is_write

    function automatic logic is_rw_data(input fsr_pkg::fsr_cmd_t c);
        is_rw_data = (c == fsr_pkg::FSR_CMD_READ_DATA) ||
                     (c == fsr_pkg::FSR_CMD_READ_DELETED) ||
                     (c == fsr_pkg::FSR_CMD_WRITE_DATA) ||
                     (c == fsr_pkg::FSR_CMD_WRITE_DELETED);
    endfunction : is_rw_data

    wire exec      = (state_q == fsr_pkg::FSR_ST_EXEC);
    // Software resets; the two are ORed, either one alone forces reset
    wire soft_rst  = ocr_q | rate_q;
    wire track_bad = evt.id_valid && (evt.id_track != cur_track);
    wire eoc_ev    = evt.sector_past_end ||
                     (evt.data_cmd_end && !evt.terminal_count && is_rw_data(cmd_q));
    wire idx_miss  = evt.index_pulse_pin && (idx_q == `FSR_IDX_LIMIT - 2'h1)
                     && !evt.id_mark_seen;
    wire sec_miss  = (evt.sector_missing &&
                      (cmd_q == fsr_pkg::FSR_CMD_READ_DATA ||
                       cmd_q == fsr_pkg::FSR_CMD_READ_DELETED)) ||
                     (evt.id_read_fail && cmd_q == fsr_pkg::FSR_CMD_READ_ID) ||
                     (evt.sequence_wrong && cmd_q == fsr_pkg::FSR_CMD_READ_TRACK);
    wire mismatch  = (cmd_q == fsr_pkg::FSR_CMD_READ_DATA && evt.deleted_mark) ||
                     (cmd_q == fsr_pkg::FSR_CMD_READ_DELETED && evt.normal_mark);

    wire [7:0] st1_set = {eoc_ev, 1'b0, evt.id_crc_fail | evt.data_crc_fail,
                          evt.service_late, 1'b0, sec_miss,
                          pins.write_protect_pin & is_write(cmd_q),
                          idx_miss | evt.no_data_mark};
    wire [7:0] st2_set = {1'b0, mismatch, evt.data_crc_fail,
                          track_bad, 2'b00,
                          track_bad && (evt.id_track == `FSR_HARD_TRACK),
                          evt.no_data_mark};

    // Events gathered only while executing; start clears, same-cycle set still wins
    always_comb
    begin
        st1_d = cmd_start ? `FSR_BYTE_ZERO : st1_q;
        st2_d = cmd_start ? `FSR_BYTE_ZERO : st2_q;
        if (exec)
        begin
            st1_d = st1_d | st1_set;
            st2_d = st2_d | st2_set;
        end
        st1_d[6] = 1'b0;
        st1_d[3] = 1'b0;
        st2_d[7] = 1'b0;
        st2_d[3] = 1'b0;
        st2_d[2] = 1'b0;
    end

    always_comb
    begin
        st3_d = `FSR_BYTE_ZERO;
        st3_d[`FSR_S3_WP]     = pins.write_protect_pin;
        st3_d[`FSR_S3_T0]     = pins.track_zero_pin;
        st3_d[`FSR_S3_HD]     = pins.head_select_pin;
        st3_d[`FSR_S3_DS_HI:`FSR_S3_DS_LO] = pins.drive_select_state;
        st3_d[`FSR_S3_ONE_HI] = 1'b1;
        st3_d[`FSR_S3_ONE_LO] = 1'b1;
    end

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            fsr_pkg::FSR_ST_RESET: if (!soft_rst) state_d = fsr_pkg::FSR_ST_IDLE;
            fsr_pkg::FSR_ST_IDLE:  if (cmd_start) state_d = fsr_pkg::FSR_ST_EXEC;
            fsr_pkg::FSR_ST_EXEC:  if (evt.data_cmd_end) state_d = fsr_pkg::FSR_ST_IDLE;
            default:               state_d = fsr_pkg::FSR_ST_RESET;
        endcase
        if (soft_rst)
            state_d = fsr_pkg::FSR_ST_RESET;
    end

    // Hardware reset lands in reset state with the control bit set
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= fsr_pkg::FSR_ST_RESET;
            ocr_q   <= 1'b1;
            rate_q  <= 1'b0;
            pd_q    <= 1'b0;
            poll_q  <= 1'b0;
            cfg_q   <= `FSR_BYTE_ZERO;
            st1_q   <= `FSR_BYTE_ZERO;
            st2_q   <= `FSR_BYTE_ZERO;
            st3_q   <= `FSR_BYTE_ZERO;
            cmd_q   <= fsr_pkg::FSR_CMD_OTHER;
            idx_q   <= 2'h0;
            srst_q  <= 1'b1;
        end
        else if (ce)
        begin
            state_q <= state_d;
            if (ocr_reset_wr)
                ocr_q <= ocr_reset_val;
            rate_q  <= rate_reset_wr & ~rate_q;
            srst_q  <= soft_rst;
            if (soft_rst)
                pd_q <= 1'b0;
            else if (power_down_req)
                pd_q <= 1'b1;
            if (soft_rst)
            begin
                cfg_q  <= `FSR_BYTE_ZERO;
                poll_q <= 1'b0;
            end
            else if (cfg_wr)
            begin
                cfg_q  <= cfg_val;
                poll_q <= ~cfg_poll_dis;
            end
            else if (srst_q)
                poll_q <= 1'b1;
            st1_q   <= soft_rst ? `FSR_BYTE_ZERO : st1_d;
            st2_q   <= soft_rst ? `FSR_BYTE_ZERO : st2_d;
            st3_q   <= st3_d;
            if (cmd_start)
                cmd_q <= cmd_kind;
            if (cmd_start || evt.id_mark_seen)
                idx_q <= 2'h0;
            else if (evt.index_pulse_pin && idx_q != `FSR_IDX_LIMIT)
                idx_q <= idx_q + 2'h1;
        end
    end

    // Specify values survive hardware reset; unknown until first loaded
    always_ff @(posedge clk)
    begin
        if (ce && spec_wr)
            spec_q <= spec_val;
    end

    assign result_status_one  = st1_q;
    assign result_status_two  = st2_q;
    assign drive_state_status = st3_q;
    assign core_reset         = srst_q;
    assign ocr_reset_bit      = ocr_q;
    assign power_down         = pd_q;
    assign poll_enable        = poll_q;
    assign cfg_settings       = cfg_q;
    assign spec_settings      = spec_q;
    assign core_state         = state_q;

    property p_unused_zero;
        @(posedge clk) disable iff (rst)
        st1_q[6] == 1'b0 && st1_q[3] == 1'b0 && st2_q[7] == 1'b0 && st2_q[3:2] == 2'b00;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bit set");

    property p_st3_ones;
        @(posedge clk) disable iff (rst)
        ce |=> st3_q[5] && st3_q[3] && st3_q[6] == $past(pins.write_protect_pin);
    endproperty
    a_st3_ones: assert property (p_st3_ones) else $error("status three wrong");

    property p_crc;
        @(posedge clk) disable iff (rst)
        ce && exec && !soft_rst && evt.data_crc_fail |=> st1_q[5] && st2_q[5];
    endproperty
    a_crc: assert property (p_crc) else $error("crc flag missed");

    property p_late;
        @(posedge clk) disable iff (rst)
        ce && exec && !soft_rst && evt.service_late |=> st1_q[4];
    endproperty
    a_late: assert property (p_late) else $error("late flag missed");

    property p_track;
        @(posedge clk) disable iff (rst)
        ce && exec && !soft_rst && track_bad |=> st2_q[4];
    endproperty
    a_track: assert property (p_track) else $error("track flag missed");

    property p_clear;
        @(posedge clk) disable iff (rst)
        ce && cmd_start && !exec |=> st1_q == `FSR_BYTE_ZERO;
    endproperty
    a_clear: assert property (p_clear) else $error("flags not cleared");

    property p_rate_self;
        @(posedge clk) disable iff (rst)
        ce && rate_q |=> !rate_q;
    endproperty
    a_rate_self: assert property (p_rate_self) else $error("rate reset stuck");

    property p_pd_exit;
        @(posedge clk) disable iff (rst)
        ce && soft_rst |=> !pd_q ##0 state_q == fsr_pkg::FSR_ST_RESET;
    endproperty
    a_pd_exit: assert property (p_pd_exit) else $error("reset not taken");

    property p_eoc;
        @(posedge clk) disable iff (rst)
        ce && exec && !soft_rst && eoc_ev |=> st1_q[7];
    endproperty
    a_eoc: assert property (p_eoc) else $error("end of cylinder missed");

    property p_sec;
        @(posedge clk) disable iff (rst)
        ce && exec && !soft_rst && sec_miss |=> st1_q[2];
    endproperty
    a_sec: assert property (p_sec) else $error("sector flag missed");

    property p_wprot;
        @(posedge clk) disable iff (rst)
        ce && exec && !soft_rst && pins.write_protect_pin && is_write(cmd_q) |=> st1_q[1];
    endproperty
    a_wprot: assert property (p_wprot) else $error("write block missed");

    property p_nomark;
        @(posedge clk) disable iff (rst)
        ce && exec && !soft_rst && evt.no_data_mark |=> st1_q[0] && st2_q[0];
    endproperty
    a_nomark: assert property (p_nomark) else $error("mark flag missed");

    property p_mismatch;
        @(posedge clk) disable iff (rst)
        ce && exec && !soft_rst && mismatch |=> st2_q[6];
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("mark mismatch missed");

    property p_bad;
        @(posedge clk) disable iff (rst)
        ce && exec && !soft_rst && track_bad && evt.id_track == `FSR_HARD_TRACK |=> st2_q[1];
    endproperty
    a_bad: assert property (p_bad) else $error("bad track missed");

    property p_ocr_hold;
        @(posedge clk) disable iff (rst)
        ce && ocr_q && !ocr_reset_wr |=> ocr_q && state_q == fsr_pkg::FSR_ST_RESET;
    endproperty
    a_ocr_hold: assert property (p_ocr_hold) else $error("control reset dropped");

    property p_st3_pins;
        @(posedge clk) disable iff (rst)
        ce |=> st3_q[4] == $past(pins.track_zero_pin) && st3_q[7] == 1'b0;
    endproperty
    a_st3_pins: assert property (p_st3_pins) else $error("status three pins wrong");

endmodule : fsr_status_reset

// [verification/fsr_host_model.sv]
module fsr_host_model (
    input  wire logic       clk,           // Core clock
    input  wire logic       rst,           // Hardware reset
    input  wire logic       clear_req,     // Ask to clear the reset bit
    input  wire logic       set_req,       // Ask to set the reset bit
    input  wire logic [2:0] dly,           // Service delay in cycles
    output logic            ocr_reset_wr,  // Write strobe
    output logic            ocr_reset_val  // Value written
);
    timeunit 1ns;
    timeprecision 1ns;
    logic v;

    initial
    begin
        ocr_reset_wr = 1'b0;
        ocr_reset_val = 1'b1;
    end

    // A slow host may leave the bit set for several cycles
    always @(posedge clk)
    begin
        if (!rst && (clear_req || set_req))
        begin
            v = set_req;
            repeat (dly) @(posedge clk);
            ocr_reset_wr <= 1'b1;
            ocr_reset_val <= v;
            @(posedge clk);
            ocr_reset_wr <= 1'b0;
            ocr_reset_val <= ~v;
        end
    end
endmodule : fsr_host_model

// [verification/test_floppy_status_and_reset.sv]
module test_floppy_status_and_reset;
    timeunit 1ns;
    timeprecision 1ns;
    typedef fsr_pkg::fsr_cmd_t fsr_k_t;
    localparam fsr_k_t RD = fsr_pkg::FSR_CMD_READ_DATA;
    localparam fsr_k_t RDD = fsr_pkg::FSR_CMD_READ_DELETED;
    localparam fsr_k_t WR = fsr_pkg::FSR_CMD_WRITE_DATA;
    localparam fsr_k_t WD = fsr_pkg::FSR_CMD_WRITE_DELETED;
    localparam fsr_k_t FMT = fsr_pkg::FSR_CMD_FORMAT;
    localparam fsr_k_t RID = fsr_pkg::FSR_CMD_READ_ID;
    localparam fsr_k_t RTR = fsr_pkg::FSR_CMD_READ_TRACK;
    logic clk, rst, ce, cmd_start, ocr_reset_wr, ocr_reset_val, rate_reset_wr;
    logic power_down_req, cfg_wr, cfg_poll_dis, spec_wr, clear_req, set_req;
    logic core_reset, ocr_reset_bit, power_down, poll_enable;
    logic [7:0] cur_track, cfg_val, spec_val, result_status_one, result_status_two;
    logic [7:0] drive_state_status, cfg_settings, spec_settings, sv;
    logic [2:0] dly;
    fsr_k_t cmd_kind;
    fsr_pkg::fsr_event_t evt;
    fsr_pkg::fsr_pins_t pins;
    fsr_pkg::fsr_state_t core_state;
    logic [11:0] q[$];
    logic [11:0] n;
    logic [7:0] obs [10];
    string nm [10] = '{"st1", "st2", "st3", "state", "ocr_bit", "core_reset",
                       "power_down", "poll", "cfg", "spec"};
    int miscompares = 0;
    int checks_done = 0;
    event look;

    assign obs = '{result_status_one, result_status_two, drive_state_status,
                   {6'h00, core_state}, {7'h00, ocr_reset_bit}, {7'h00, core_reset},
                   {7'h00, power_down}, {7'h00, poll_enable}, cfg_settings, spec_settings};

    fsr_status_reset fsr_status_reset_i (.clk(clk), .rst(rst), .ce(ce), .cmd_start(cmd_start),
        .cmd_kind(cmd_kind), .cur_track(cur_track), .evt(evt), .pins(pins),
        .ocr_reset_wr(ocr_reset_wr), .ocr_reset_val(ocr_reset_val),
        .rate_reset_wr(rate_reset_wr), .power_down_req(power_down_req), .cfg_wr(cfg_wr),
        .cfg_poll_dis(cfg_poll_dis), .cfg_val(cfg_val), .spec_wr(spec_wr),
        .spec_val(spec_val), .result_status_one(result_status_one),
        .result_status_two(result_status_two), .drive_state_status(drive_state_status),
        .core_reset(core_reset), .ocr_reset_bit(ocr_reset_bit), .power_down(power_down),
        .poll_enable(poll_enable), .cfg_settings(cfg_settings),
        .spec_settings(spec_settings), .core_state(core_state));

    fsr_host_model fsr_host_model_i (.clk(clk), .rst(rst), .clear_req(clear_req),
        .set_req(set_req), .dly(dly), .ocr_reset_wr(ocr_reset_wr),
        .ocr_reset_val(ocr_reset_val));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    task automatic note(input logic [3:0] id, input logic [7:0] v);
        q.push_back({id, v});
        -> look;
        #1;
    endtask : note

    task automatic tk(input int c);
        repeat (c) @(posedge clk);
    endtask : tk

    // Bounded wait; the closing note flags a hang
    task automatic wait_idle();
        int i;
        i = 0;
        while (core_state !== fsr_pkg::FSR_ST_IDLE && i < 20)
        begin
            @(posedge clk);
            #1;
            i++;
        end
        note(3, {6'h00, fsr_pkg::FSR_ST_IDLE});
    endtask : wait_idle

    task automatic release_core();
        @(posedge clk);
        dly <= 3'($urandom_range(3));
        clear_req <= 1'b1;
        @(posedge clk);
        clear_req <= 1'b0;
        wait_idle();
        tk(2);
        #1;
        note(5, 8'h00);
        note(7, 8'h01);
        note(8, 8'h00);
    endtask : release_core

    task automatic run(input fsr_k_t k, input int b, input logic wp, input logic [7:0] s1,
                       input logic [7:0] s2, input logic [7:0] trk = 8'h05);
        fsr_pkg::fsr_event_t e;
        e = '0;
        if (b >= 0)
            e[b] = 1'b1;
        e.id_track = trk;
        @(posedge clk);
        cmd_kind <= k;
        cmd_start <= 1'b1;
        @(posedge clk);
        cmd_start <= 1'b0;
        #1;
        note(3, {6'h00, fsr_pkg::FSR_ST_EXEC});
        note(0, 8'h00);
        note(1, 8'h00);
        repeat (e.index_pulse_pin ? 2 : 1)
        begin
            @(posedge clk);
            evt <= e;
            pins.write_protect_pin <= wp;
            @(posedge clk);
            evt <= '0;
        end
        tk(1);
        #1;
        note(0, s1);
        note(1, s2);
        @(posedge clk);
        evt.data_cmd_end <= 1'b1;
        evt.terminal_count <= 1'b1;
        pins.write_protect_pin <= 1'b0;
        @(posedge clk);
        evt <= '0;
        wait_idle();
        note(0, s1);
    endtask : run

    initial
    begin
        forever
        begin
            @(look);
            while (q.size() > 0)
            begin
                n = q.pop_front();
                checks_done++;
                if (obs[n[11:8]] !== n[7:0])
                begin
                    miscompares++;
                    $display("CHECK FAILED %s exp %h got %h", nm[n[11:8]], n[7:0], obs[n[11:8]]);
                end
            end
        end
    end

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial
    begin
        #500000;
        miscompares++;
        finish_test();
    end

    initial
    begin
        void'($urandom(9661));
        {ce, rst, cmd_start, rate_reset_wr, power_down_req} = 5'h18;
        {cfg_wr, cfg_poll_dis, spec_wr, clear_req, set_req, dly} = '0;
        {cfg_val, spec_val, cur_track} = {8'h00, 8'h00, 8'h05};
        cmd_kind = fsr_pkg::FSR_CMD_OTHER;
        evt = '0;
        pins = '0;
        tk(3);
        rst <= 1'b0;
        #1;
        note(3, 8'h00);
        note(4, 8'h01);
        note(5, 8'h01);
        release_core();
        repeat (4)
        begin
            @(posedge clk);
            pins <= 5'($urandom);
            tk(2);
            #1;
            note(2, {1'b0, pins.write_protect_pin, 1'b1, pins.track_zero_pin, 1'b1,
                     pins.head_select_pin, pins.drive_select_state});
        end
        @(posedge clk);
        pins.write_protect_pin <= 1'b0;
        run(RD, 22, 1'b0, 8'h80, 8'h00);
        run(WR, 21, 1'b0, 8'h80, 8'h00);
        run(RD, 19, 1'b0, 8'h20, 8'h00);
        run(WR, 17, 1'b0, 8'h10, 8'h00);
        run(RD, 16, 1'b0, 8'h04, 8'h00);
        run(RID, 15, 1'b0, 8'h04, 8'h00);
        run(RTR, 14, 1'b0, 8'h04, 8'h00);
        run(WR, -1, 1'b1, 8'h02, 8'h00);
        run(WD, -1, 1'b1, 8'h02, 8'h00);
        run(FMT, -1, 1'b1, 8'h02, 8'h00);
        run(RD, -1, 1'b1, 8'h00, 8'h00);
        run(RD, 13, 1'b0, 8'h01, 8'h00);
        run(RD, 11, 1'b0, 8'h01, 8'h01);
        run(RD, 10, 1'b0, 8'h00, 8'h40);
        run(RDD, 9, 1'b0, 8'h00, 8'h40);
        run(RD, 8, 1'b0, 8'h00, 8'h10, 8'h06);
        run(RD, 8, 1'b0, 8'h00, 8'h12, 8'hFF);
        run(RD, 8, 1'b0, 8'h00, 8'h00);
        run(RD, 18, 1'b0, 8'h20, 8'h20);
        @(posedge clk);
        {cfg_wr, cfg_poll_dis, cfg_val} <= {2'b11, 8'($urandom)};
        @(posedge clk);
        cfg_wr <= 1'b0;
        tk(2);
        #1;
        note(8, cfg_val);
        note(7, 8'h00);
        @(posedge clk);
        power_down_req <= 1'b1;
        @(posedge clk);
        power_down_req <= 1'b0;
        tk(2);
        #1;
        note(6, 8'h01);
        @(posedge clk);
        rate_reset_wr <= 1'b1;
        @(posedge clk);
        rate_reset_wr <= 1'b0;
        tk(3);
        #1;
        wait_idle();
        note(6, 8'h00);
        note(8, 8'h00);
        note(0, 8'h00);
        tk(2);
        #1;
        note(7, 8'h01);
        @(posedge clk);
        set_req <= 1'b1;
        @(posedge clk);
        set_req <= 1'b0;
        tk(3);
        rate_reset_wr <= 1'b1;
        @(posedge clk);
        rate_reset_wr <= 1'b0;
        tk(4);
        #1;
        note(4, 8'h01);
        note(5, 8'h01);
        release_core();
        @(posedge clk);
        spec_val <= 8'($urandom);
        spec_wr <= 1'b1;
        @(posedge clk);
        spec_wr <= 1'b0;
        sv = spec_val;
        cmd_kind <= WR;
        cmd_start <= 1'b1;
        power_down_req <= 1'b1;
        @(posedge clk);
        {cmd_start, power_down_req} <= 2'b00;
        tk(1);
        #30;
        rst = 1'b1;
        tk(3);
        rst <= 1'b0;
        #1;
        note(3, 8'h00);
        note(6, 8'h00);
        note(9, sv);
        release_core();
        finish_test();
    end
endmodule : test_floppy_status_and_reset
